// ### seq_pkg.sv
// shared constants and types for the display rail sequencer
package seq_pkg;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_MHZ       = 100;   // core clock rate
  localparam int SEQ_GAP_US    = 2000;  // sequencing / discharge gap
  localparam int BST_SS_US     = 470;   // boost ramp at default level
  localparam int VP_SS_LONG_US = 1200;  // positive ramp, long select
  localparam int VN_SS_LONG_US = 1800;  // negative ramp, long select
  localparam int SS_SHORT_US   = 700;   // both ramps, short select
  localparam int ABS_GAP_US    = 33000; // audio band pulse gap limit
  localparam int BST_DEF_STEPS = 103;   // default boost level, 50mV units
  localparam int VP_DEF_STEPS  = 100;   // default positive level
  localparam int VN_DEF_STEPS  = 100;   // default negative magnitude

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [7:0] REG_CTRL   = 8'h04; // control: start together, reboot
  localparam logic [7:0] REG_ENABLE = 8'h05; // enables and options
  localparam logic [7:0] REG_BST_V  = 8'h06; // boost level step code
  localparam logic [7:0] REG_VN_V   = 8'h08; // negative level code
  localparam logic [7:0] REG_VP_V   = 8'h09; // positive level code
  localparam logic [7:0] REG_FREQ   = 8'h0d; // boost control, pfm
  localparam logic [7:0] REG_PFM2   = 8'h0e; // charge pump pfm
  localparam logic [7:0] REG_STATUS = 8'h10; // live rail state
  localparam logic [7:0] CTRL_RST   = 8'h00;
  localparam logic [7:0] ENABLE_RST = 8'h27;
  localparam logic [7:0] FREQ_RST   = 8'hb4;
  localparam logic [7:0] ZERO_RST   = 8'h00;

  // bit positions
  localparam int B_TOGETHER = 4; // ctrl: start both rails together
  localparam int B_REBOOT   = 7; // ctrl: reload all defaults
  localparam int B_EN_BST   = 0; // enable: boost
  localparam int B_EN_VN    = 1; // enable: negative rail
  localparam int B_EN_VP    = 2; // enable: positive rail
  localparam int B_FAST_OFF = 4; // enable: positive off with pin
  localparam int B_HIZ      = 6; // enable: discharge paths removed
  localparam int B_SS_SHORT = 7; // enable: short ramp select
  localparam int B_PFM_DIS  = 3; // freq: boost pfm disable
  localparam int B_VN_PFM_DIS = 0; // pfm2: charge pump pfm disable

  // charge pump switching
  localparam logic [7:0] CP_PERIOD = 8'd100; // cycles per period
  localparam logic [7:0] CP_MIN_ON = 8'd10;  // pfm minimum on time

  // ****************************************************************
  // types
  // ****************************************************************
  localparam int CNT_W = 24;
  typedef logic [CNT_W-1:0] cnt_t;

  // external levels, all asynchronous to clk
  typedef struct packed {
    logic pos_rail_enable_pin;        // pos_rail_enable_pin
    logic neg_rail_enable_pin;        // neg_rail_enable_pin
    logic in_ok;      // input_supply above input_lockout
    logic light_load; // load comparator says light load
    logic bst_pulse;  // boost switching pulse seen
  } pins_t;

  // rail controls toward the analog blocks
  typedef struct packed {
    logic bst_en;     // boost_rail enable
    logic vp_en;      // positive_rail enable
    logic vn_en;      // negative_rail enable
    logic vp_dis;     // positive discharge resistor on
    logic vn_dis;     // negative discharge resistor on
  } rails_t;

  // register port request
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef enum logic [1:0] {
    BST_OFF   = 2'b00,
    BST_RAMP  = 2'b01,
    BST_READY = 2'b10
  } bst_state_t;

endpackage

// ### cp_duty_limiter.sv
// charge pump gate generator with a half period duty ceiling
`timescale 1ns/10ps
module cp_duty_limiter
  import seq_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       resetn,
  // control
  input  wire logic       run,      // negative rail enabled
  input  wire logic       pulse_frequency_operation,      // light load pulse frequency mode
  input  wire logic [7:0] duty_req, // wanted duty, fraction of 256
  // gate
  output logic            gate
);

  localparam logic [7:0] HALF = CP_PERIOD >> 1;

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic [7:0] phase;  // position inside the period
    logic [7:0] target; // on cycles for this period
    logic [7:0] on_cnt; // on cycles spent this period
    logic       gate;
  } cp_st_t;

  cp_st_t st_r;
  cp_st_t st_nxt;
  logic [15:0] scaled; // request scaled to the period
  logic [7:0]  tgt;    // clamped target

  // next state: target captured at phase zero, capped at half
  always_comb begin
    st_nxt = st_r;
    scaled = duty_req * {8'h00, CP_PERIOD};
    tgt    = scaled[15:8];
    if (pulse_frequency_operation && tgt < CP_MIN_ON) begin
      tgt = CP_MIN_ON;
    end
    if (tgt > HALF) begin
      tgt = HALF;
    end
    if (st_r.phase == CP_PERIOD - 8'd1) begin
      st_nxt.phase  = 8'h00;
      st_nxt.target = tgt;
      st_nxt.on_cnt = 8'h00;
    end else begin
      st_nxt.phase = st_r.phase + 8'd1;
    end
    st_nxt.gate = run && (st_nxt.phase < st_nxt.target);
    if (st_nxt.gate) begin
      st_nxt.on_cnt = st_nxt.on_cnt + 8'd1;
    end
  end

  // state register
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign gate = st_r.gate;

  // ****************************************************************
  // checks
  // ****************************************************************
  chk_duty_half_period: assert property (
    @(posedge clk) disable iff (!resetn) st_r.on_cnt <= HALF)
    else $error("charge pump on time exceeds half period");

endmodule

// ### display_rail_sequencer.sv
// sequencer for boost, positive and negative display rails
//
// Chosen here: the register addresses and the plain strobed port.
`timescale 1ns/10ps
// Operation
// - boost runs with supply, pin, enable bit
// - positive rail needs pin, boost ready, bit
// - negative rail after later of gap, pin
// - start-together mode skips the gap
// - two soft-start selections by select bit
// - ramp time scales with target level
// - negative off with its pin; both low
// - positive and boost off delay option
// - supply lockout turns every rail off
// - positive discharge for gap after pin
// - positive discharge again on positive pin fall
// - high impedance bit removes discharge paths
// - three enable bits reset to one
// - pulse frequency only when its bit permits
// - audio band suppression on long pulse gaps
// - charge pump duty at most half period
module display_rail_sequencer
  import seq_pkg::*;
#(
  parameter int SEQ_GAP_CYC = SEQ_GAP_US * CLK_MHZ,
  parameter int BST_SS_CYC  = BST_SS_US * CLK_MHZ,
  parameter int VP_SS_CYC   = VP_SS_LONG_US * CLK_MHZ,
  parameter int VN_SS_CYC   = VN_SS_LONG_US * CLK_MHZ,
  parameter int SHORT_CYC   = SS_SHORT_US * CLK_MHZ,
  parameter int ABS_GAP_CYC = ABS_GAP_US * CLK_MHZ
)(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       resetn,
  // register port
  input  wire reg_req_t   req,
  output logic [7:0]      rdata,
  // pins and analog indications
  input  wire pins_t      pins,
  input  wire logic [7:0] cp_duty_req,
  // rail controls
  output rails_t          rails,
  output logic            ss_short_sel,
  output logic            bst_pfm,
  output logic            vn_pfm,
  output logic            abs_peak_reduce,
  output logic            abs_reverse,
  output logic            cp_gate
);

  localparam cnt_t GAP = cnt_t'(SEQ_GAP_CYC);
  localparam cnt_t ABS1 = cnt_t'(ABS_GAP_CYC);
  localparam cnt_t ABS2 = cnt_t'(2 * ABS_GAP_CYC);

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    pins_t      s1;       // first sync stage
    pins_t      s2;       // second sync stage
    pins_t      s3;       // delayed copy for edges
    logic [7:0] ctrl;     // start together option
    logic [7:0] en;       // enable and option bits
    logic [7:0] bst_v;    // boost level code
    logic [7:0] vn_v;     // negative level code
    logic [7:0] vp_v;     // positive level code
    logic [7:0] freq;     // boost pfm option
    logic [7:0] pfm2;     // charge pump pfm option
    logic [7:0] rdata;    // read answer
    bst_state_t bst;      // boost phase
    cnt_t       bst_cnt;  // boost ramp left
    cnt_t       gap_cnt;  // negative start gap left
    cnt_t       hold_cnt; // positive off delay left
    cnt_t       dis_cnt;  // positive discharge window left
    cnt_t       vp_ss;    // positive ramp left
    cnt_t       vn_ss;    // negative ramp left
    cnt_t       abs_cnt;  // time since last boost pulse
    rails_t     rails;    // registered rail controls
    logic       bst_pfm;
    logic       vn_pfm;
    logic       peak_red;
    logic       rev_cyc;
  } st_t;

  localparam st_t ST_RST = '{ctrl: CTRL_RST, en: ENABLE_RST,
                             freq: FREQ_RST, bst: BST_OFF, default: '0};

  st_t  st_r;
  st_t  st_nxt;
  logic pos_rail_enable_pin;       // synced positive pin
  logic neg_rail_enable_pin;       // synced negative pin
  logic in_ok;     // synced supply good
  logic enp_fall;
  logic enn_fall;
  logic pos_want;  // positive rail still wanted
  logic bst_want;  // boost wanted
  logic gap_done;
  logic vp_go;
  logic vn_go;
  logic [7:0] rd_val;

  // ramp length from base time and level step code
  function automatic cnt_t ss_cycles(input cnt_t base,
                                     input logic [7:0] code,
                                     input int steps);
    cnt_t step;
    step = base / cnt_t'(steps);
    return base + step * cnt_t'(code);
  endfunction

  // register read decode
  function automatic logic [7:0] rd_mux(input st_t s,
                                        input logic [7:0] a);
    logic [7:0] v;
    v = 8'h00;
    case (a)
      REG_CTRL:   v = s.ctrl;
      REG_ENABLE: v = s.en;
      REG_BST_V:  v = s.bst_v;
      REG_VN_V:   v = s.vn_v;
      REG_VP_V:   v = s.vp_v;
      REG_FREQ:   v = s.freq;
      REG_PFM2:   v = s.pfm2;
      REG_STATUS: v = {s.rev_cyc, s.peak_red, s.vn_ss == '0,
                       s.vp_ss == '0, s.bst == BST_READY,
                       s.rails.vn_en, s.rails.vp_en, s.rails.bst_en};
      default:    v = 8'h00;
    endcase
    return v;
  endfunction

  // ****************************************************************
  // decode of synced inputs
  // ****************************************************************
  assign pos_rail_enable_pin      = st_r.s2.pos_rail_enable_pin;
  assign neg_rail_enable_pin      = st_r.s2.neg_rail_enable_pin;
  assign in_ok    = st_r.s2.in_ok;
  assign enp_fall = st_r.s3.pos_rail_enable_pin && !pos_rail_enable_pin;
  assign enn_fall = st_r.s3.neg_rail_enable_pin && !neg_rail_enable_pin;
  // the fall edge itself keeps the rail, so no gap opens before hold loads
  assign pos_want = pos_rail_enable_pin || (st_r.hold_cnt != '0)
                    || (enp_fall && !st_r.en[B_FAST_OFF]);
  assign bst_want = in_ok && st_r.en[B_EN_BST]
                    && (neg_rail_enable_pin || pos_want);
  assign gap_done = st_r.gap_cnt == '0;
  assign vp_go    = st_r.bst == BST_READY && bst_want
                    && st_r.en[B_EN_VP] && pos_want;
  assign vn_go    = st_r.bst == BST_READY && bst_want
                    && st_r.en[B_EN_VN] && neg_rail_enable_pin
                    && (st_r.ctrl[B_TOGETHER] || gap_done);
  assign rd_val   = rd_mux(st_r, req.addr);

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    st_nxt = st_r;
    // pin synchronisers
    st_nxt.s1 = pins;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;

    // register writes; reboot reloads every default
    if (req.wr) begin
      case (req.addr)
        REG_CTRL:   st_nxt.ctrl  = req.wdata & ~(8'h01 << B_REBOOT);
        REG_ENABLE: st_nxt.en    = req.wdata;
        REG_BST_V:  st_nxt.bst_v = req.wdata;
        REG_VN_V:   st_nxt.vn_v  = req.wdata;
        REG_VP_V:   st_nxt.vp_v  = req.wdata;
        REG_FREQ:   st_nxt.freq  = req.wdata;
        REG_PFM2:   st_nxt.pfm2  = req.wdata;
        default:    st_nxt.ctrl  = st_nxt.ctrl;
      endcase
      if (req.addr == REG_CTRL && req.wdata[B_REBOOT]) begin
        st_nxt.ctrl  = ST_RST.ctrl;
        st_nxt.en    = ST_RST.en;
        st_nxt.bst_v = ST_RST.bst_v;
        st_nxt.vn_v  = ST_RST.vn_v;
        st_nxt.vp_v  = ST_RST.vp_v;
        st_nxt.freq  = ST_RST.freq;
        st_nxt.pfm2  = ST_RST.pfm2;
      end
    end
    // read data stands only in the cycle after the strobe
    st_nxt.rdata = req.rd ? rd_val : 8'h00;

    // positive off delay, restarted on every positive pin fall while the fast off bit is clear
    if (pos_rail_enable_pin) begin
      st_nxt.hold_cnt = '0;
    end else if (enp_fall && !st_r.en[B_FAST_OFF]) begin
      st_nxt.hold_cnt = GAP;
    end else if (st_r.hold_cnt != '0) begin
      st_nxt.hold_cnt = st_r.hold_cnt - cnt_t'(1);
    end

    // boost phase
    case (st_r.bst)
      BST_OFF: begin
        // a fresh start needs a live pin, not just a pending off delay
        if (bst_want && (pos_rail_enable_pin || neg_rail_enable_pin)) begin
          st_nxt.bst     = BST_RAMP;
          st_nxt.bst_cnt = ss_cycles(cnt_t'(BST_SS_CYC), st_r.bst_v,
                                     BST_DEF_STEPS);
        end
      end
      BST_RAMP: begin
        if (!bst_want) begin
          st_nxt.bst = BST_OFF;
        end else if (st_r.bst_cnt == '0) begin
          st_nxt.bst     = BST_READY;
          st_nxt.gap_cnt = GAP;
        end else begin
          st_nxt.bst_cnt = st_r.bst_cnt - cnt_t'(1);
        end
      end
      BST_READY: begin
        if (!bst_want) begin
          st_nxt.bst = BST_OFF;
        end else if (!gap_done) begin
          st_nxt.gap_cnt = st_r.gap_cnt - cnt_t'(1);
        end
      end
      default: st_nxt.bst = BST_OFF;
    endcase

    // output rails and their ramp timers
    st_nxt.rails.bst_en = bst_want && st_r.bst != BST_OFF;
    st_nxt.rails.vp_en  = vp_go;
    st_nxt.rails.vn_en  = vn_go;
    if (vp_go && !st_r.rails.vp_en) begin
      st_nxt.vp_ss = ss_cycles(st_r.en[B_SS_SHORT] ?
                               cnt_t'(SHORT_CYC) : cnt_t'(VP_SS_CYC),
                               st_r.vp_v, VP_DEF_STEPS);
    end else if (st_r.vp_ss != '0) begin
      st_nxt.vp_ss = st_r.vp_ss - cnt_t'(1);
    end
    if (vn_go && !st_r.rails.vn_en) begin
      st_nxt.vn_ss = ss_cycles(st_r.en[B_SS_SHORT] ?
                               cnt_t'(SHORT_CYC) : cnt_t'(VN_SS_CYC),
                               st_r.vn_v, VN_DEF_STEPS);
    end else if (st_r.vn_ss != '0) begin
      st_nxt.vn_ss = st_r.vn_ss - cnt_t'(1);
    end

    // positive discharge window after negative pin fall
    if (enn_fall) begin
      st_nxt.dis_cnt = GAP;
    end else if (st_r.dis_cnt != '0) begin
      st_nxt.dis_cnt = st_r.dis_cnt - cnt_t'(1);
    end
    // the fall edge engages the path at once, the window then holds it
    st_nxt.rails.vp_dis = !st_r.en[B_HIZ]
                          && (enn_fall || st_r.dis_cnt != '0
                              || !pos_rail_enable_pin);
    st_nxt.rails.vn_dis = !st_r.en[B_HIZ] && !vn_go;

    // light load modes only where permitted
    st_nxt.bst_pfm = !st_r.freq[B_PFM_DIS] && st_r.s2.light_load
                     && st_r.bst == BST_READY;
    st_nxt.vn_pfm  = !st_r.pfm2[B_VN_PFM_DIS] && st_r.s2.light_load
                     && st_r.rails.vn_en;

    // audio band suppression: time the gap between boost pulses
    if (!st_r.bst_pfm || (st_r.s2.bst_pulse && !st_r.s3.bst_pulse)) begin
      st_nxt.abs_cnt = '0;
    end else if (st_r.abs_cnt < ABS2) begin
      st_nxt.abs_cnt = st_r.abs_cnt + cnt_t'(1);
    end
    st_nxt.peak_red = st_r.bst_pfm && st_r.abs_cnt >= ABS1;
    st_nxt.rev_cyc  = st_r.bst_pfm && st_r.abs_cnt >= ABS2;
  end

  // state register
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_r <= ST_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign rdata           = st_r.rdata;
  assign rails           = st_r.rails;
  assign ss_short_sel    = st_r.en[B_SS_SHORT];
  assign bst_pfm         = st_r.bst_pfm;
  assign vn_pfm          = st_r.vn_pfm;
  assign abs_peak_reduce = st_r.peak_red;
  assign abs_reverse     = st_r.rev_cyc;

  cp_duty_limiter u_cp (
    .clk      (clk),
    .resetn   (resetn),
    .run      (st_r.rails.vn_en),
    .pulse_frequency_operation      (st_r.vn_pfm),
    .duty_req (cp_duty_req),
    .gate     (cp_gate)
  );

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  chk_boost_start_cause: assert property (
    $rose(st_r.bst != BST_OFF) |-> $past(in_ok && st_r.en[B_EN_BST]
                                          && (pos_rail_enable_pin || neg_rail_enable_pin)))
    else $error("boost started without supply, pin and enable");
  chk_vp_start_cause: assert property (
    $rose(st_r.rails.vp_en) |-> $past(st_r.bst == BST_READY
                                      && st_r.en[B_EN_VP] && pos_rail_enable_pin))
    else $error("positive rail started early");
  chk_vn_gap_wait: assert property (
    $rose(st_r.rails.vn_en) && !$past(st_r.ctrl[B_TOGETHER])
    |-> $past(gap_done && neg_rail_enable_pin && st_r.en[B_EN_VN]))
    else $error("negative rail started before gap");
  chk_start_together: assert property (
    st_r.ctrl[B_TOGETHER] && vp_go && neg_rail_enable_pin && st_r.en[B_EN_VN]
    |=> st_r.rails.vp_en && st_r.rails.vn_en)
    else $error("rails did not start together");
  chk_vp_ramp_select: assert property (
    $rose(st_r.rails.vp_en) && st_r.vp_v == 8'h00
    |-> st_r.vp_ss == (st_r.en[B_SS_SHORT] ? cnt_t'(SHORT_CYC)
                                           : cnt_t'(VP_SS_CYC)))
    else $error("positive ramp length wrong");
  chk_vn_off_now: assert property (
    enn_fall |=> !st_r.rails.vn_en)
    else $error("negative rail not off with its pin");
  chk_vp_off_delay: assert property (
    enp_fall && !st_r.en[B_FAST_OFF] && !req.wr && in_ok
    && st_r.rails.vp_en |=> st_r.rails.vp_en [*2])
    else $error("positive rail dropped without delay");
  chk_lockout_all_off: assert property (
    !in_ok |=> !st_r.rails.vp_en && !st_r.rails.vn_en
               && st_r.bst == BST_OFF)
    else $error("rail left on under lockout");
  chk_vp_disch_window: assert property (
    enn_fall && !st_r.en[B_HIZ] && !req.wr |=> st_r.rails.vp_dis)
    else $error("positive discharge not engaged");
  chk_hiz_no_disch: assert property (
    st_r.en[B_HIZ] && $past(st_r.en[B_HIZ])
    |-> !st_r.rails.vp_dis && !st_r.rails.vn_dis)
    else $error("discharge path on in high impedance mode");
  chk_pfm_permit: assert property (
    st_r.bst_pfm |-> $past(!st_r.freq[B_PFM_DIS]))
    else $error("boost pfm while disabled");
  chk_abs_peak: assert property (
    st_r.bst_pfm && st_r.abs_cnt >= ABS1 |=> st_r.peak_red)
    else $error("peak current not reduced on long gap");

  cov_seq_start: cover property (
    $rose(st_r.rails.vn_en) && !st_r.ctrl[B_TOGETHER]);
  cov_together: cover property (
    $rose(st_r.rails.vp_en) && $rose(st_r.rails.vn_en));
  cov_delayed_off: cover property (
    $fell(st_r.rails.vp_en) && !st_r.en[B_FAST_OFF]);
  cov_abs_reverse: cover property ($rose(st_r.rev_cyc));

endmodule

// ### host_gpio.sv
// host side model: gpio enable pins and supply indication
`timescale 1ns/10ps
module host_gpio
  import seq_pkg::*;
(
  // clock
  input  wire logic clk,
  // levels asked for by the bench
  input  wire logic enp_set,
  input  wire logic enn_set,
  input  wire logic ok_set,
  input  wire logic light_set,
  input  wire logic pulse_set,
  // pins toward the sequencer
  output pins_t     pins
);
  // ****************************************************************
  // pins change just after an edge, like a real gpio write
  // ****************************************************************
  initial pins = '0;
  always @(posedge clk) begin
    pins.pos_rail_enable_pin        <= enp_set;
    pins.neg_rail_enable_pin        <= enn_set;
    pins.in_ok      <= ok_set;
    pins.light_load <= light_set;
    pins.bst_pulse  <= pulse_set;
  end
endmodule

// ### tb_display_rail_sequencer.sv
// self checking bench for the display rail sequencer
`timescale 1ns/10ps
module tb_display_rail_sequencer;
  import seq_pkg::*;
  // ****************************************************************
  // signals
  // ****************************************************************
  logic       clk, resetn, pos_rail_enable_pin, neg_rail_enable_pin, ok;
  reg_req_t   req;
  logic [7:0] rdata;
  pins_t      pins;
  rails_t     rails;
  logic       ss_short_sel;
  logic       bst_pfm, vn_pfm, peak, rev, cp_gate, light, pulse;
  logic [7:0] duty;
  int         n_mismatch, total_checks, i;

  host_gpio host_gpio_inst (.clk(clk), .enp_set(pos_rail_enable_pin), .enn_set(neg_rail_enable_pin),
    .ok_set(ok), .light_set(light), .pulse_set(pulse), .pins(pins));
  display_rail_sequencer #(.SEQ_GAP_CYC(20), .BST_SS_CYC(10),
    .VP_SS_CYC(30), .VN_SS_CYC(40), .SHORT_CYC(15), .ABS_GAP_CYC(50))
  display_rail_sequencer_inst (.clk(clk), .resetn(resetn), .req(req),
    .rdata(rdata), .pins(pins), .cp_duty_req(duty), .rails(rails),
    .ss_short_sel(ss_short_sel), .bst_pfm(bst_pfm), .vn_pfm(vn_pfm),
    .abs_peak_reduce(peak), .abs_reverse(rev), .cp_gate(cp_gate));

  // ****************************************************************
  // helpers
  // ****************************************************************
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    req <= '0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk);
    req <= '0;
    #1 chk(rdata, exp);
  endtask
  task automatic wait_vp;
    // look after each edge has settled, never in the edge's own step
    for (i = 0; i < 200 && rails.vp_en !== 1'b1; i++) wt(1);
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset_map;
    rd(REG_ENABLE, ENABLE_RST);
    rd(REG_CTRL, CTRL_RST);
    rd(8'h03, 8'h00);
    $display("test reset_map done");
  endtask
  task automatic t_seq_on_off;
    pos_rail_enable_pin <= 1'b1;
    neg_rail_enable_pin <= 1'b1;
    wt(8);
    chk(rails.bst_en, 1'b1);
    chk(rails.vp_en, 1'b0);
    wait_vp;
    chk(rails.vp_en, 1'b1);
    wt(12);
    chk(rails.vn_en, 1'b0);
    wt(12);
    chk(rails.vn_en, 1'b1);
    neg_rail_enable_pin <= 1'b0;
    wt(6);
    chk(rails.vn_en, 1'b0);
    chk(rails.vp_dis, 1'b1);
    chk(rails.vn_dis, 1'b1);
    wt(25);
    chk(rails.vp_dis, 1'b0);
    pos_rail_enable_pin <= 1'b0;
    wt(6);
    chk(rails.vp_en, 1'b1);
    chk(rails.vp_dis, 1'b1);
    wt(25);
    chk({rails.vp_en, rails.bst_en}, 2'b00);
    $display("test seq_on_off done");
  endtask
  task automatic t_together;
    wr(REG_CTRL, 8'h10);
    pos_rail_enable_pin <= 1'b1;
    neg_rail_enable_pin <= 1'b1;
    wait_vp;
    wt(2);
    chk(rails.vn_en, 1'b1);
    wr(REG_ENABLE, 8'h37);
    pos_rail_enable_pin <= 1'b0;
    neg_rail_enable_pin <= 1'b0;
    wt(6);
    chk({rails.vp_en, rails.vn_en, rails.bst_en}, 3'b000);
    $display("test together done");
  endtask
  task automatic t_lockout;
    pos_rail_enable_pin <= 1'b1;
    neg_rail_enable_pin <= 1'b1;
    wait_vp;
    wt(4);
    ok <= 1'b0;
    wt(6);
    chk({rails.vp_en, rails.vn_en, rails.bst_en}, 3'b000);
    ok <= 1'b1;
    pos_rail_enable_pin <= 1'b0;
    neg_rail_enable_pin <= 1'b0;
    wt(30);
    $display("test lockout done");
  endtask
  task automatic t_pfm;
    logic [7:0] n;
    duty <= 8'hff;
    light <= 1'b1;
    pos_rail_enable_pin <= 1'b1;
    neg_rail_enable_pin <= 1'b1;
    wait_vp;
    wt(3);
    chk(bst_pfm, 1'b1);
    chk(vn_pfm, 1'b1);
    chk(peak, 1'b0);
    wt(100);
    chk(peak, 1'b1);
    chk(rev, 1'b1);
    n = 8'h00;
    repeat (100) begin
      wt(1);
      n = n + {7'h00, cp_gate};
    end
    chk(n, 8'd50);
    pulse <= 1'b1;
    wt(6);
    chk({peak, rev}, 2'b00);
    pulse <= 1'b0;
    wr(REG_FREQ, 8'hbc);
    wr(REG_PFM2, 8'h01);
    wt(2);
    chk({bst_pfm, vn_pfm}, 2'b00);
    light <= 1'b0;
    pos_rail_enable_pin <= 1'b0;
    neg_rail_enable_pin <= 1'b0;
    wt(8);
    $display("test pfm done");
  endtask
  task automatic t_bits;
    wr(REG_ENABLE, 8'he6);
    wt(6);
    chk(ss_short_sel, 1'b1);
    chk({rails.vp_dis, rails.vn_dis}, 2'b00);
    pos_rail_enable_pin <= 1'b1;
    neg_rail_enable_pin <= 1'b1;
    wt(30);
    chk(rails.bst_en, 1'b0);
    $display("test bits done");
  endtask

  // ****************************************************************
  // clock, reset, sequence and watchdog
  // ****************************************************************
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    resetn = 1'b0;
    req = '0;
    pos_rail_enable_pin = 1'b0;
    neg_rail_enable_pin = 1'b0;
    ok = 1'b1;
    light = 1'b0;
    pulse = 1'b0;
    duty = 8'h40;
    n_mismatch = 0;
    total_checks = 0;
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    t_reset_map;
    t_seq_on_off;
    t_together;
    t_lockout;
    t_pfm;
    t_bits;
    results;
  end
  initial begin
    #200us;
    n_mismatch++;
    results;
  end
endmodule
